/* rtl/rdp_regs.vh */
`ifndef RDP_REGS_VH
`define RDP_REGS_VH
// Summary of operation
// (R1) With reset function selected, a low sampled on the shared pin resets the device.
// (R2) Any internal reset source drives the shared reset pin low.
// (R3) Power-on reset restores the shared pin to reset-input function; only power-on does.
// (R4) Other resets leave the shared pin function selection as software left it.
// (R5) Reset-input function selected means the shared pin pull-up is connected.
// (R6) In interrupt mode the pin feeds interrupt request and branch-on-level, asynchronous input.
// (R7) Debug pin is mode select during reset, background pin after release.
// (R8) As background/mode pin, debug pin has pull-up and standard output driver.
// (R9) Background enable set by every reset; cleared to allow port or comparator use.
// (R10) Mode select high at reset release starts normal mode.
// (R11) Mode select held low at power-on or debug reset enters background mode.
// (R12) Each background debug bit lasts 16 debug clock cycles.
// (R13) Debug pin is pseudo open-drain with short driven-high speedup pulses.
// (R14) Port pins offer per-bit software pull-up, effective only as inputs.
// (R15) Pulls off for outputs, except the two open-drain bits in serial mode.
// (R16) Debug pin as port bit is output only, pull disabled.
// (R17) Open-drain bits only drive low or release, never drive high.
// (R18) After any reset all port pins are high impedance with pull-ups off.
// (R19) Asynchronous interrupt and reset inputs pass a two-stage synchroniser first.

// Register byte offsets
`define RDP_OPT_ADDR      12'h000
`define RDP_DIR_ADDR      12'h004
`define RDP_OUT_ADDR      12'h008
`define RDP_PULL_ADDR     12'h00c
`define RDP_IN_ADDR       12'h010
`define RDP_STAT_ADDR     12'h014
`define RDP_DBG_ADDR      12'h018
// Option register fields
`define RDP_OPT_RSTPE     0
`define RDP_OPT_BGEN      1
`define RDP_OPT_IIC       2
`define RDP_OPT_ACMP      3
`define RDP_OPT_RESET     32'h0000_0003
// Debug bit timing
`define RDP_BIT_CYCLES    16
`define RDP_SPEEDUP_CYC   2
`define RDP_DBG_DRIVE_BIT 8
`endif

/* rtl/rdp_bit_timer.v */
`include "rdp_regs.vh"
module rdp_bit_timer #(
    parameter CYCLES = `RDP_BIT_CYCLES,
    parameter PULSE  = `RDP_SPEEDUP_CYC
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Bit request and level
    input  wire       start,
    input  wire       level,
    // Pin drive
    output reg        busy,
    output reg        drive_oe,
    output reg        drive_val
);
    reg [4:0] cnt_reg;

    // One debug bit: low for a quarter, then data, speedup high pulse on release
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg   <= 5'h00;
            busy      <= 1'b0;
            drive_oe  <= 1'b0;
            drive_val <= 1'b0;
        end
        else if (!busy)
        begin
            if (start)
            begin
                busy      <= 1'b1;
                cnt_reg   <= 5'h00;
                drive_oe  <= 1'b1;
                drive_val <= 1'b0;
            end
        end
        else
        begin
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == CYCLES - 1)                    // R12
            begin
                busy     <= 1'b0;
                drive_oe <= 1'b0;
            end
            else if (cnt_reg == CYCLES / 4 - 1)
            begin
                drive_oe  <= 1'b1;                        // R13
                drive_val <= level;
            end
            else if (level && cnt_reg == CYCLES / 4 - 1 + PULSE)
                drive_oe <= 1'b0;                         // R13
            else if (!level && cnt_reg == (CYCLES * 3) / 4)
            begin
                drive_val <= 1'b1;                        // R13
            end
            else if (!level && cnt_reg == (CYCLES * 3) / 4 + PULSE)
                drive_oe <= 1'b0;
        end
    end
endmodule

/* rtl/rdp_pin_ctrl.v */
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`include "rdp_regs.vh"
module rdp_pin_ctrl #(
    parameter PORT_W = 8
) (
    // Clock and resets
    input  wire              clk,
    input  wire              rst_n,
    input  wire              por_n,
    input  wire              int_rst_req,
    input  wire              dbg_force_rst,
    // AHB-Lite slave
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire [31:0]       hrdata,
    output wire              hreadyout,
    output wire              hresp,
    // Shared reset and interrupt pin
    input  wire              shared_reset_irq_pin_in,
    output wire              shared_reset_irq_pin_out,
    output wire              shared_reset_irq_pin_oe,
    output wire              shared_reset_irq_pin_pu,
    // Background debug pin
    input  wire              background_debug_pin_in,
    output wire              background_debug_pin_out,
    output wire              background_debug_pin_oe,
    output wire              background_debug_pin_pu,
    // General port pins
    input  wire [PORT_W-1:0] port_in,
    output wire [PORT_W-1:0] port_out,
    output wire [PORT_W-1:0] port_oe,
    output wire [PORT_W-1:0] port_pu,
    // System outputs and comparator input
    output wire              sys_rst_n,
    output wire              irq_level,
    output wire              irq_req,
    output reg               background_mode,
    input  wire              comparator_output
);
    localparam OD_LO = 2;
    localparam OD_HI = 3;

    reg              rs1_reg, rs2_reg;
    reg              pin1_reg, pin2_reg;
    reg              ms1_reg, ms2_reg;
    reg              in_rst_reg;
    reg              por_seen_reg;
    reg              dbg_rst_seen_reg;
    reg              irq_prev_reg;
    reg              rstpe_reg;
    reg              bgen_reg;
    reg              iic_reg;
    reg              acmp_reg;
    reg [PORT_W-1:0] dir_reg;
    reg [PORT_W-1:0] out_reg;
    reg [PORT_W-1:0] pull_reg;
    reg [PORT_W-1:0] pin_s1_reg, pin_s2_reg;
    reg [7:0]        dbg_tx_reg;
    reg              dbg_start_reg;
    reg              ap_we_reg;
    reg              ap_re_reg;
    reg [11:0]       ap_addr_reg;
    reg [31:0]       rdata_reg;
    wire             dbg_busy;
    wire             dbg_oe;
    wire             dbg_val;
    wire             ext_rst;
    wire             any_rst_n;
    wire             ap_valid;

    // Synchronise the reset release
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end
        else
        begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end

    // Two-stage synchronisers for asynchronous pin inputs
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
        begin
            pin1_reg   <= 1'b1;
            pin2_reg   <= 1'b1;
            ms1_reg    <= 1'b1;
            ms2_reg    <= 1'b1;
            pin_s1_reg <= {PORT_W{1'b0}};
            pin_s2_reg <= {PORT_W{1'b0}};
        end
        else
        begin
            pin1_reg   <= shared_reset_irq_pin_in;        // R19
            pin2_reg   <= pin1_reg;                       // R19
            ms1_reg    <= background_debug_pin_in;
            ms2_reg    <= ms1_reg;
            pin_s1_reg <= port_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // External reset only counts when the reset function is selected
    assign ext_rst   = rstpe_reg && !pin2_reg;            // R1
    assign any_rst_n = rs2_reg && por_n && !ext_rst && !int_rst_req && !dbg_force_rst;
    assign sys_rst_n = any_rst_n;

    // Internal reset stretches one cycle to mark the release edge
    always @(posedge clk or negedge any_rst_n)
    begin
        if (!any_rst_n)
            in_rst_reg <= 1'b1;
        else
            in_rst_reg <= 1'b0;
    end

    // Remember which reset kind came last, for mode entry
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
        begin
            por_seen_reg     <= 1'b1;
            dbg_rst_seen_reg <= 1'b0;
        end
        else if (!por_n)
            por_seen_reg <= 1'b1;
        else if (dbg_force_rst)
            dbg_rst_seen_reg <= 1'b1;
        else if (!in_rst_reg)
        begin
            por_seen_reg     <= 1'b0;
            dbg_rst_seen_reg <= 1'b0;
        end
    end

    // Mode latched at the reset release edge
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
            background_mode <= 1'b0;
        else if (in_rst_reg && any_rst_n)
            background_mode <= (por_seen_reg || dbg_rst_seen_reg) && !ms2_reg; // R10 R11
    end

    // Pin selection survives all resets but power-on
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
            rstpe_reg <= 1'b1;
        else if (!por_n)
            rstpe_reg <= 1'b1;                            // R3
        else if (ap_we_reg && ap_addr_reg == `RDP_OPT_ADDR && any_rst_n)
            rstpe_reg <= hwdata[`RDP_OPT_RSTPE];          // R4
    end

    // Remaining options and port state return on every reset
    always @(posedge clk or negedge any_rst_n)
    begin
        if (!any_rst_n)
        begin
            bgen_reg   <= 1'b1;                           // R9
            iic_reg    <= 1'b0;
            acmp_reg   <= 1'b0;
            dir_reg    <= {PORT_W{1'b0}};                 // R18
            out_reg    <= {PORT_W{1'b0}};
            pull_reg   <= {PORT_W{1'b0}};                 // R18
            dbg_tx_reg <= 8'h00;
        end
        else if (ap_we_reg)
        begin
            case (ap_addr_reg)
                `RDP_OPT_ADDR:
                begin
                    bgen_reg   <= hwdata[`RDP_OPT_BGEN];
                    iic_reg    <= hwdata[`RDP_OPT_IIC];
                    acmp_reg   <= hwdata[`RDP_OPT_ACMP];
                end
                `RDP_DIR_ADDR:  dir_reg <= hwdata[PORT_W-1:0];
                `RDP_OUT_ADDR:  out_reg <= hwdata[PORT_W-1:0];
                `RDP_PULL_ADDR: pull_reg <= hwdata[PORT_W-1:0];
                `RDP_DBG_ADDR:  dbg_tx_reg <= hwdata[7:0];
                default:        dir_reg <= dir_reg;
            endcase
        end
    end

    // Debug bit launch on write to the debug register
    always @(posedge clk or negedge any_rst_n)
    begin
        if (!any_rst_n)
            dbg_start_reg <= 1'b0;
        else
            dbg_start_reg <= ap_we_reg && ap_addr_reg == `RDP_DBG_ADDR && bgen_reg;
    end

    rdp_bit_timer u_bit (
        .clk       (clk),
        .rst_n     (any_rst_n),
        .start     (dbg_start_reg),
        .level     (dbg_tx_reg[0]),
        .busy      (dbg_busy),
        .drive_oe  (dbg_oe),
        .drive_val (dbg_val)
    );

    // AHB-Lite address phase capture, zero wait states
    assign ap_valid = hsel && hready && htrans[1];
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
        begin
            ap_we_reg   <= 1'b0;
            ap_re_reg   <= 1'b0;
            ap_addr_reg <= 12'h000;
        end
        else
        begin
            ap_we_reg   <= ap_valid && hwrite;
            ap_re_reg   <= ap_valid && !hwrite;
            ap_addr_reg <= haddr[11:0];
        end
    end

    // Read data registered at the address phase
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
            rdata_reg <= 32'h0000_0000;
        else if (ap_valid && !hwrite)
        begin
            case (haddr[11:0])
                `RDP_OPT_ADDR:  rdata_reg <= {28'h0, acmp_reg, iic_reg, bgen_reg, rstpe_reg};
                `RDP_DIR_ADDR:  rdata_reg <= {{(32-PORT_W){1'b0}}, dir_reg};
                `RDP_OUT_ADDR:  rdata_reg <= {{(32-PORT_W){1'b0}}, out_reg};
                `RDP_PULL_ADDR: rdata_reg <= {{(32-PORT_W){1'b0}}, pull_reg};
                `RDP_IN_ADDR:   rdata_reg <= {{(32-PORT_W){1'b0}}, pin_s2_reg};
                `RDP_STAT_ADDR: rdata_reg <= {28'h0, dbg_busy, background_mode, ms2_reg, pin2_reg};
                default:        rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Shared pin: drive low on internal reset, pull-up in reset mode
    assign shared_reset_irq_pin_out = 1'b0;
    assign shared_reset_irq_pin_oe  = !rs2_reg || !por_n || int_rst_req || dbg_force_rst; // R2
    assign shared_reset_irq_pin_pu  = rstpe_reg;          // R5

    // Interrupt level and falling edge request when not in reset mode
    always @(posedge clk or negedge rs2_reg)
    begin
        if (!rs2_reg)
            irq_prev_reg <= 1'b1;
        else
            irq_prev_reg <= pin2_reg;
    end
    assign irq_level = rstpe_reg ? 1'b1 : pin2_reg;       // R6
    assign irq_req   = !rstpe_reg && irq_prev_reg && !pin2_reg; // R6

    // Debug pin: mode select in reset, background or port output after
    assign background_debug_pin_oe  = in_rst_reg ? 1'b0 :
                                      bgen_reg ? dbg_oe : 1'b1; // R7 R16
    assign background_debug_pin_out = bgen_reg ? dbg_val :
                                      acmp_reg ? comparator_output : out_reg[4];
    assign background_debug_pin_pu  = in_rst_reg || bgen_reg; // R8 R16

    // Port pins: pull only as input, or on a released open-drain bit in serial mode; open-drain bits never drive high
    genvar g;
    generate
        for (g = 0; g < PORT_W; g = g + 1)
        begin : g_port
            if (g == OD_LO || g == OD_HI)
            begin : g_od
                assign port_out[g] = 1'b0;                                 // R17
                assign port_oe[g]  = dir_reg[g] && !out_reg[g];            // R17
                assign port_pu[g]  = pull_reg[g] && (!dir_reg[g] ||
                                     (iic_reg && out_reg[g]));             // R15
            end
            else
            begin : g_pp
                assign port_out[g] = out_reg[g];
                assign port_oe[g]  = dir_reg[g];
                assign port_pu[g]  = pull_reg[g] && !dir_reg[g];           // R14 R15
            end
        end
    endgenerate
endmodule

/* verification/rdp_pin_chk.sv */
module rdp_pin_chk #(
    parameter PORT_W = 8
) (
    // Clock and resets
    input wire              clk,
    input wire              rst_n,
    input wire              por_n,
    input wire              int_rst_req,
    // Bus response
    input wire              hreadyout,
    input wire              hresp,
    // Pins
    input wire              shared_reset_irq_pin_in,
    input wire              shared_reset_irq_pin_out,
    input wire              shared_reset_irq_pin_oe,
    input wire              shared_reset_irq_pin_pu,
    input wire              background_debug_pin_oe,
    input wire              background_debug_pin_pu,
    input wire [PORT_W-1:0] port_out,
    input wire [PORT_W-1:0] port_oe,
    input wire [PORT_W-1:0] port_pu,
    // System outputs
    input wire              sys_rst_n,
    input wire              irq_level,
    input wire              irq_req
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [PORT_W-1:0] OD = PORT_W'(8'h0c);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Reset pin held low by the board while the reset function is chosen
    sequence ext_low;
        shared_reset_irq_pin_pu && !shared_reset_irq_pin_in;
    endsequence
    // Interrupt request is a lone pulse
    sequence irq_one;
        !shared_reset_irq_pin_pu ##1 !irq_req;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    a_rst_drive: assert property (int_rst_req |-> shared_reset_irq_pin_oe &&
        !shared_reset_irq_pin_out) else $error("reset pin not driven low");
    a_ext_reset: assert property (ext_low [*3] |-> ##[0:3] !sys_rst_n)
        else $error("pin low gave no reset");
    a_rst_pull: assert property (shared_reset_irq_pin_pu [*2] |-> irq_level)
        else $error("interrupt level active in reset mode");
    a_irq_pulse: assert property (irq_req |-> irq_one)
        else $error("interrupt pulse wrong");
    a_irq_sync: assert property ((!shared_reset_irq_pin_pu && !shared_reset_irq_pin_in) [*3]
        |-> !irq_level) else $error("interrupt level not following pin");
    a_od_low: assert property ((port_oe & port_out & OD) == 0)
        else $error("open drain bit drives high");
    a_pull_out: assert property ((port_oe & port_pu & ~OD) == 0)
        else $error("pull left on output");
    a_dbg_mode_in: assert property ((!por_n) [*4] |-> !background_debug_pin_oe &&
        background_debug_pin_pu) else $error("debug pin not mode input");
    a_port_reset: assert property ((!por_n || int_rst_req) [*4] |->
        port_oe == 0 && port_pu == 0) else $error("port not released in reset");
endmodule

bind rdp_pin_ctrl rdp_pin_chk #(.PORT_W(PORT_W)) rdp_pin_chk_i (
    .clk, .rst_n, .por_n, .int_rst_req, .hreadyout, .hresp, .shared_reset_irq_pin_in,
    .shared_reset_irq_pin_out, .shared_reset_irq_pin_oe, .shared_reset_irq_pin_pu,
    .background_debug_pin_oe, .background_debug_pin_pu, .port_out, .port_oe,
    .port_pu, .sys_rst_n, .irq_level, .irq_req
);

/* verification/rdp_far_model.sv */
module rdp_far_model #(
    parameter PORT_W = 8
) (
    // Clock and board controls
    input  wire               clk,
    input  wire               board_pin_low,
    input  wire               mode_sel_low,
    // Shared pin
    input  wire               shared_reset_irq_pin_out,
    input  wire               shared_reset_irq_pin_oe,
    input  wire               shared_reset_irq_pin_pu,
    output logic              shared_reset_irq_pin_in,
    // Debug pin
    input  wire               background_debug_pin_out,
    input  wire               background_debug_pin_oe,
    input  wire               background_debug_pin_pu,
    output logic              background_debug_pin_in,
    // Port loads
    input  wire  [PORT_W-1:0] port_out,
    input  wire  [PORT_W-1:0] port_oe,
    input  wire  [PORT_W-1:0] port_pu,
    output logic [PORT_W-1:0] port_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic              srp_last = 1'b0;
    logic              dbg_last = 1'b0;
    logic [PORT_W-1:0] port_last = '0;
    // Device drive wins, then a switch or host to ground, then pull-up; else the pin drifts
    always_comb
    begin
        shared_reset_irq_pin_in = shared_reset_irq_pin_oe ? shared_reset_irq_pin_out :
            board_pin_low ? 1'b0 : shared_reset_irq_pin_pu | ~srp_last;
        background_debug_pin_in = background_debug_pin_oe ? background_debug_pin_out :
            mode_sel_low ? 1'b0 : background_debug_pin_pu | ~dbg_last;
        port_in = (port_oe & port_out) | (~port_oe & (port_pu | ~port_last));
    end
    // Last levels, inverted when nothing holds the line
    always @(posedge clk)
    begin
        srp_last <= shared_reset_irq_pin_in;
        dbg_last <= background_debug_pin_in;
        port_last <= port_in;
    end
endmodule

/* verification/rdp_pin_ctrl_tb.sv */
`include "rdp_regs.vh"
module rdp_pin_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por_n = 1'b0;
    logic        int_rst_req = 1'b0;
    logic        dbg_force_rst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        board_pin_low = 1'b0;
    logic        mode_sel_low = 1'b0;
    logic        comparator_output = 1'b0;
    logic [31:0] rq;
    int          num_errors = 0;
    int          compares = 0;
    wire  [31:0] hrdata;
    wire  [7:0]  port_in, port_out, port_oe, port_pu;
    wire         hreadyout, hresp, sys_rst_n, irq_level, irq_req, background_mode;
    wire         shared_reset_irq_pin_in, shared_reset_irq_pin_out;
    wire         shared_reset_irq_pin_oe, shared_reset_irq_pin_pu;
    wire         background_debug_pin_in, background_debug_pin_out;
    wire         background_debug_pin_oe, background_debug_pin_pu;

    rdp_pin_ctrl rdp_pin_ctrl_i (
        .clk, .rst_n, .por_n, .int_rst_req, .dbg_force_rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .shared_reset_irq_pin_in, .shared_reset_irq_pin_out, .shared_reset_irq_pin_oe,
        .shared_reset_irq_pin_pu, .background_debug_pin_in, .background_debug_pin_out,
        .background_debug_pin_oe, .background_debug_pin_pu, .port_in, .port_out,
        .port_oe, .port_pu, .sys_rst_n, .irq_level, .irq_req, .background_mode,
        .comparator_output
    );
    rdp_far_model rdp_far_model_i (
        .clk, .board_pin_low, .mode_sel_low, .shared_reset_irq_pin_out,
        .shared_reset_irq_pin_oe,
        .shared_reset_irq_pin_pu, .shared_reset_irq_pin_in, .background_debug_pin_out,
        .background_debug_pin_oe, .background_debug_pin_pu, .background_debug_pin_in,
        .port_out, .port_oe, .port_pu, .port_in
    );

    // Bus clock, 100 ns period
    always #50 clk = ~clk;

    // Compare one observed value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rq = hrdata;
        @(negedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    // Read and compare the masked bits
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rq & m, e);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(32'(port_oe | port_pu), 32'h0);
        chk(32'(shared_reset_irq_pin_pu), 32'h1);
        chk(32'(background_mode), 32'h0);
        rdc(`RDP_OPT_ADDR, 32'hf, `RDP_OPT_RESET);
        wr(12'h01c, 32'hffff_ffff);
        rdc(12'h01c, 32'hffff_ffff, 32'h0);
        wr(`RDP_DIR_ADDR, 32'h0f);
        wr(`RDP_PULL_ADDR, 32'hff);
        wr(`RDP_OUT_ADDR, 32'hff);
        chk(32'(port_pu), 32'hf0);
        chk(32'(port_oe), 32'h03);
        chk(32'(port_out & 8'h0c), 32'h0);
        wr(`RDP_OUT_ADDR, 32'h00);
        chk(32'(port_oe), 32'h0f);
        wr(`RDP_IN_ADDR, 32'h0f);
        rdc(`RDP_IN_ADDR, 32'hff, 32'hf0);
        // Shared pin as interrupt, debug pin as comparator output
        wr(`RDP_OPT_ADDR, 32'h8);
        chk(32'(shared_reset_irq_pin_pu), 32'h0);
        chk(32'(background_debug_pin_pu), 32'h0);
        chk(32'(background_debug_pin_oe), 32'h1);
        @(posedge clk);
        comparator_output <= 1'b1;
        board_pin_low <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(32'(background_debug_pin_out), 32'h1);
        chk(32'(irq_level), 32'h0);
        chk(32'(irq_req), 32'h0);
        chk(32'(sys_rst_n), 32'h1);
        // Internal reset keeps the pin selection
        @(posedge clk);
        board_pin_low <= 1'b0;
        int_rst_req <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(32'(shared_reset_irq_pin_in), 32'h0);
        chk(32'(port_oe), 32'h0);
        @(posedge clk);
        int_rst_req <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(`RDP_OPT_ADDR, 32'hb, 32'h2);
        // Debug bit busy through its sixteenth cycle, idle three cycles later
        wr(`RDP_DBG_ADDR, 32'h1);
        repeat (`RDP_BIT_CYCLES - 1) @(posedge clk);
        rdc(`RDP_STAT_ADDR, 32'h8, 32'h8);
        rdc(`RDP_STAT_ADDR, 32'h8, 32'h0);
        // Power-on with mode select held low
        @(posedge clk);
        mode_sel_low <= 1'b1;
        por_n <= 1'b0;
        repeat (6) @(posedge clk);
        por_n <= 1'b1;
        repeat (6) @(posedge clk);
        mode_sel_low <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(32'(background_mode), 32'h1);
        rdc(`RDP_OPT_ADDR, 32'h3, 32'h3);
        // Switch to ground, then a debug forced reset with mode select floating
        @(posedge clk);
        board_pin_low <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(32'(sys_rst_n), 32'h0);
        @(posedge clk);
        board_pin_low <= 1'b0;
        dbg_force_rst <= 1'b1;
        repeat (3) @(posedge clk);
        dbg_force_rst <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(32'(background_mode), 32'h0);
        wrap_up;
    end

    // Watchdog, about twenty-five times the expected run
    initial
    begin
        repeat (3000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
endmodule
